// File: rtl/lbx_params.svh
// constants of the logic, branch and bit-clear execute slice
// assumes one core clock, each clock edge being one quarter phase
`ifndef LBX_PARAMS_SVH
`define LBX_PARAMS_SVH

// ----------------------------------------------------------------
// opcode prefixes
// ----------------------------------------------------------------
`define OPC_ADD_CARRY    6'h08
`define OPC_AND_FILE     6'h05
`define OPC_BRANCH_CARRY 8'he2
`define OPC_BIT_CLEAR    4'h9

// ----------------------------------------------------------------
// instruction field positions
// ----------------------------------------------------------------
`define FLD_D        9
`define FLD_A        8
`define FLD_BIT_HI   11
`define FLD_BIT_LO   9
`define FLD_F_HI     7
`define FLD_SIGN     7

// ----------------------------------------------------------------
// addressing
// ----------------------------------------------------------------
`define ACCESS_SPLIT 8'h60
`define INDEX_LIMIT  8'h5f
`define BANK_LOW     4'h0
`define BANK_SFR     4'hf

// ----------------------------------------------------------------
// status bit positions, reset values, pc step and single-bit mask
// ----------------------------------------------------------------
`define ST_C         0
`define ST_DC        1
`define ST_Z         2
`define ST_OV        3
`define ST_N         4
`define STATUS_RESET 5'h00
`define W_RESET      8'h00
`define PC_RESET     21'h000000
`define PC_STEP      21'h000002
`define BIT_ONE      8'h01

`endif

// File: rtl/lbx_pkg.sv
// types of the logic, branch and bit-clear execute slice
// assumes lbx_params.svh supplies the numeric constants
`default_nettype none

package lbx_pkg;

  // quarter phases of one instruction cycle
  typedef enum logic [1:0] {
    PH_DECODE  = 2'b00,
    PH_READ    = 2'b01,
    PH_PROCESS = 2'b10,
    PH_WRITE   = 2'b11
  } phase_e;

  // operations carried in this slice
  typedef enum logic [2:0] {
    OP_NOP          = 3'b000,
    OP_ADD_CARRY    = 3'b001,
    OP_AND_FILE     = 3'b010,
    OP_BRANCH_CARRY = 3'b011,
    OP_BIT_CLEAR    = 3'b100
  } op_e;

endpackage : lbx_pkg

`default_nettype wire

// File: rtl/logic_branch_bitclr_exec.sv
// decode and execute of add-carry, and-with-file, branch-on-carry, bit-clear
// assumes fetch logic on CORE_CLK presents INSTR at the decode phase and
// file memory answers FILE_ADDR combinationally by the process phase
`timescale 1ns/1ps
`default_nettype none
`include "lbx_params.svh"

module logic_branch_bitclr_exec (
  input  wire logic        CORE_CLK,
  input  wire logic        RST,
  input  wire logic [15:0] INSTR,
  input  wire logic        INSTR_VALID,
  input  wire logic        EXT_SET_EN,
  input  wire logic [3:0]  BANK_SELECT,
  input  wire logic [7:0]  FILE_RDATA,
  output var  logic [20:0] PC,
  output var  logic [11:0] FILE_ADDR,
  output var  logic [7:0]  FILE_WDATA,
  output var  logic        FILE_WE,
  output var  logic [7:0]  W_REG,
  output var  logic [4:0]  STATUS_FLAGS,
  output var  logic        INDEXED_SEL,
  output var  logic [1:0]  PHASE
);

  phase_if ph ();

  phase_gen phase_gen_i (
    .CORE_CLK (CORE_CLK),
    .RST      (RST),
    .ph       (ph.gen)
  );

  lbx_pkg::op_e op_r,      op_nxt;
  logic [15:0]  ir_r,      ir_nxt;
  logic [20:0]  pc_r,      pc_nxt;
  logic [11:0]  addr_r,    addr_nxt;
  logic [7:0]   wdata_r,   wdata_nxt;
  logic         we_r,      we_nxt;
  logic [7:0]   w_r,       w_nxt;
  logic [4:0]   status_r,  status_nxt;
  logic         indexed_r, indexed_nxt;
  logic [7:0]   opnd_r,    opnd_nxt;
  logic         bubble_r,  bubble_nxt;

  // ----------------------------------------------------------------
  // datapath terms
  // ----------------------------------------------------------------
  logic [8:0]  sum9;
  logic [4:0]  low5;
  logic [7:0]  and_res;
  logic [7:0]  clr_res;
  logic [20:0] br_off;
  logic [7:0]  fa;
  logic        carry;
  logic        file_op;

  assign carry   = status_r[`ST_C];
  assign sum9    = {1'b0, w_r} + {1'b0, opnd_r} + {8'h00, carry};
  assign low5    = {1'b0, w_r[3:0]} + {1'b0, opnd_r[3:0]} + {4'h0, carry};
  assign and_res = w_r & opnd_r;
  assign clr_res = opnd_r & ~(`BIT_ONE << ir_r[`FLD_BIT_HI:`FLD_BIT_LO]);
  // sign-extended offset doubled: 12 sign bits, 8 offset bits, one zero
  assign br_off  = {{12{ir_r[`FLD_SIGN]}}, ir_r[`FLD_F_HI:0], 1'b0};
  assign fa      = ir_r[`FLD_F_HI:0];
  assign file_op = (op_r == lbx_pkg::OP_ADD_CARRY) || (op_r == lbx_pkg::OP_AND_FILE)
                   || (op_r == lbx_pkg::OP_BIT_CLEAR);

  // opcode decode; anything outside this slice runs as a no-op
  function automatic lbx_pkg::op_e decode_op(input logic [15:0] i);
    lbx_pkg::op_e o;
    o = lbx_pkg::OP_NOP;
    if (i[15:10] == `OPC_ADD_CARRY) begin
      o = lbx_pkg::OP_ADD_CARRY;
    end else if (i[15:10] == `OPC_AND_FILE) begin
      o = lbx_pkg::OP_AND_FILE;
    end else if (i[15:8] == `OPC_BRANCH_CARRY) begin
      o = lbx_pkg::OP_BRANCH_CARRY;
    end else if (i[15:12] == `OPC_BIT_CLEAR) begin
      o = lbx_pkg::OP_BIT_CLEAR;
    end
    return o;
  endfunction : decode_op

  // ----------------------------------------------------------------
  // per-phase next state
  // ----------------------------------------------------------------
  // one phase per edge keeps every single-word op to one cycle except a taken branch, which adds a bubble cycle
  always_comb begin
    op_nxt      = op_r;
    ir_nxt      = ir_r;
    pc_nxt      = pc_r;
    addr_nxt    = addr_r;
    wdata_nxt   = wdata_r;
    we_nxt      = 1'b0;
    w_nxt       = w_r;
    status_nxt  = status_r;
    indexed_nxt = indexed_r;
    opnd_nxt    = opnd_r;
    bubble_nxt  = bubble_r;
    unique case (ph.phase)
      lbx_pkg::PH_DECODE: begin
        // bubble slot after a taken branch; fetch address already moved
        if (bubble_r) begin
          op_nxt     = lbx_pkg::OP_NOP;
          bubble_nxt = 1'b0;
        end else if (INSTR_VALID) begin
          op_nxt = decode_op(INSTR);
          ir_nxt = INSTR;
          pc_nxt = pc_r + `PC_STEP;
        end else begin
          op_nxt = lbx_pkg::OP_NOP;
        end
      end
      lbx_pkg::PH_READ: begin
        if (ir_r[`FLD_A]) begin
          addr_nxt = {BANK_SELECT, fa};
        end else if (fa < `ACCESS_SPLIT) begin
          addr_nxt = {`BANK_LOW, fa};
        end else begin
          addr_nxt = {`BANK_SFR, fa};
        end
        // only the condition; the offset adder lives in the addressing unit
        indexed_nxt = file_op && !ir_r[`FLD_A] && EXT_SET_EN
                      && (fa <= `INDEX_LIMIT);
      end
      lbx_pkg::PH_PROCESS: begin
        opnd_nxt = FILE_RDATA;
      end
      lbx_pkg::PH_WRITE: begin
        unique case (op_r)
          lbx_pkg::OP_ADD_CARRY: begin
            if (ir_r[`FLD_D]) begin
              we_nxt    = 1'b1;
              wdata_nxt = sum9[7:0];
            end else begin
              w_nxt = sum9[7:0];
            end
            status_nxt[`ST_C]  = sum9[8];
            status_nxt[`ST_DC] = low5[4];
            status_nxt[`ST_Z]  = (sum9[7:0] == 8'h00);
            status_nxt[`ST_OV] = (w_r[7] == opnd_r[7]) && (sum9[7] != w_r[7]);
            status_nxt[`ST_N]  = sum9[7];
          end
          lbx_pkg::OP_AND_FILE: begin
            if (ir_r[`FLD_D]) begin
              we_nxt    = 1'b1;
              wdata_nxt = and_res;
            end else begin
              w_nxt = and_res;
            end
            status_nxt[`ST_Z] = (and_res == 8'h00);
            status_nxt[`ST_N] = and_res[7];
          end
          lbx_pkg::OP_BRANCH_CARRY: begin
            // pc already holds branch address plus two
            if (carry) begin
              pc_nxt     = pc_r + br_off;
              bubble_nxt = 1'b1;
            end
          end
          lbx_pkg::OP_BIT_CLEAR: begin
            we_nxt    = 1'b1;
            wdata_nxt = clr_res;
          end
          default: begin
          end
        endcase
      end
    endcase
  end

  // state registers
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      op_r      <= lbx_pkg::OP_NOP;
      ir_r      <= 16'h0000;
      pc_r      <= `PC_RESET;
      addr_r    <= 12'h000;
      wdata_r   <= 8'h00;
      we_r      <= 1'b0;
      w_r       <= `W_RESET;
      status_r  <= `STATUS_RESET;
      indexed_r <= 1'b0;
      opnd_r    <= 8'h00;
      bubble_r  <= 1'b0;
    end else begin
      op_r      <= op_nxt;
      ir_r      <= ir_nxt;
      pc_r      <= pc_nxt;
      addr_r    <= addr_nxt;
      wdata_r   <= wdata_nxt;
      we_r      <= we_nxt;
      w_r       <= w_nxt;
      status_r  <= status_nxt;
      indexed_r <= indexed_nxt;
      opnd_r    <= opnd_nxt;
      bubble_r  <= bubble_nxt;
    end
  end

  assign PC           = pc_r;
  assign FILE_ADDR    = addr_r;
  assign FILE_WDATA   = wdata_r;
  assign FILE_WE      = we_r;
  assign W_REG        = w_r;
  assign STATUS_FLAGS = status_r;
  assign INDEXED_SEL  = indexed_r;
  assign PHASE        = ph.phase;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (RST);

  logic wr_add, wr_and, wr_br, wr_clr;
  assign wr_add = (ph.phase == lbx_pkg::PH_WRITE) && (op_r == lbx_pkg::OP_ADD_CARRY);
  assign wr_and = (ph.phase == lbx_pkg::PH_WRITE) && (op_r == lbx_pkg::OP_AND_FILE);
  assign wr_br  = (ph.phase == lbx_pkg::PH_WRITE) && (op_r == lbx_pkg::OP_BRANCH_CARRY);
  assign wr_clr = (ph.phase == lbx_pkg::PH_WRITE) && (op_r == lbx_pkg::OP_BIT_CLEAR);

  a_add_work_sum: assert property (wr_add && !ir_r[`FLD_D] |=>
    w_r == 8'($past(w_r) + $past(opnd_r) + {7'h00, $past(carry)}))
    else $error("add with carry wrote wrong work value");
  // carry and sign rebuilt from the sampled operands, not from the adder
  a_add_carry_out: assert property (wr_add |=>
    status_r[`ST_C] == (({1'b0, $past(w_r)} + {1'b0, $past(opnd_r)} + {8'h00, $past(carry)})
                        > 9'h0ff)
    && status_r[`ST_N] == (8'($past(w_r) + $past(opnd_r) + {7'h00, $past(carry)}) > 8'h7f))
    else $error("add with carry left wrong carry or sign");
  a_indexed_pick: assert property ((ph.phase == lbx_pkg::PH_READ) && file_op
    && !ir_r[`FLD_A] && EXT_SET_EN && fa <= `INDEX_LIMIT |=> INDEXED_SEL)
    else $error("indexed offset mode not selected");
  a_and_dest: assert property (wr_and && ir_r[`FLD_D] |=>
    FILE_WE && FILE_WDATA == ($past(w_r) & $past(opnd_r)) && $stable(w_r))
    else $error("and result not written to file");
  a_and_flags_kept: assert property (wr_and |=>
    status_r[`ST_C] == $past(status_r[`ST_C]) && $stable(status_r[`ST_OV])
    && $stable(status_r[`ST_DC])
    && status_r[`ST_Z] == (($past(w_r) & $past(opnd_r)) == 8'h00))
    else $error("and touched wrong flags");
  a_bank_addr: assert property ((ph.phase == lbx_pkg::PH_READ) && ir_r[`FLD_A] |=>
    FILE_ADDR == {$past(BANK_SELECT), $past(fa)})
    else $error("bank select not used for address");
  a_branch_target: assert property (wr_br && carry |=>
    pc_r == 21'($past(pc_r) + 21'(2 * $signed($past(ir_r[`FLD_F_HI:0]))))
    && $stable(status_r))
    else $error("taken branch target wrong");
  a_branch_bubble: assert property (wr_br && carry |=> ##1
    (op_r == lbx_pkg::OP_NOP && $stable(pc_r)) [*4])
    else $error("taken branch missing idle cycle");
  a_untaken_quiet: assert property (wr_br && !carry |=>
    $stable(pc_r) && !FILE_WE && $stable(status_r))
    else $error("untaken branch wrote something");
  a_bit_clear_data: assert property (wr_clr |=> FILE_WE
    && FILE_WDATA == ($past(opnd_r) & ~(`BIT_ONE << $past(ir_r[`FLD_BIT_HI:`FLD_BIT_LO])))
    && $stable(status_r))
    else $error("bit clear result wrong");
  a_cycle_length: assert property (ph.phase == lbx_pkg::PH_DECODE |->
    ##3 ph.phase == lbx_pkg::PH_WRITE ##1 ph.phase == lbx_pkg::PH_DECODE)
    else $error("instruction cycle not four phases");

  c_branch_taken: cover property (wr_br && carry);
  c_add_to_file:  cover property (wr_add && ir_r[`FLD_D]);
  c_indexed:      cover property (INDEXED_SEL && op_r == lbx_pkg::OP_BIT_CLEAR);

endmodule : logic_branch_bitclr_exec

`default_nettype wire

// File: rtl/phase_gen.sv
// quarter-phase divider: one instruction cycle is four core clocks
// assumes synchronous active-high reset on the core clock
`timescale 1ns/1ps
`default_nettype none

module phase_gen (
  input  wire logic CORE_CLK,
  input  wire logic RST,
  phase_if.gen      ph
);

  lbx_pkg::phase_e phase_r;
  lbx_pkg::phase_e phase_nxt;

  // ----------------------------------------------------------------
  // phase sequence
  // ----------------------------------------------------------------
  // wraps freely so each instruction takes exactly four edges
  always_comb begin
    unique case (phase_r)
      lbx_pkg::PH_DECODE:  phase_nxt = lbx_pkg::PH_READ;
      lbx_pkg::PH_READ:    phase_nxt = lbx_pkg::PH_PROCESS;
      lbx_pkg::PH_PROCESS: phase_nxt = lbx_pkg::PH_WRITE;
      lbx_pkg::PH_WRITE:   phase_nxt = lbx_pkg::PH_DECODE;
    endcase
  end

  // phase register
  always_ff @(posedge CORE_CLK) begin
    if (RST) begin
      phase_r <= lbx_pkg::PH_DECODE;
    end else begin
      phase_r <= phase_nxt;
    end
  end

  assign ph.phase = phase_r;

endmodule : phase_gen

`default_nettype wire

// File: rtl/phase_if.sv
// carrier of the quarter-phase count between sequencer and core
// assumes both ends sit on the core clock
`timescale 1ns/1ps
`default_nettype none

interface phase_if;
  lbx_pkg::phase_e phase;

  modport gen (output phase);
  modport use_side (input phase);
endinterface : phase_if

`default_nettype wire

// File: verif/logic_branch_bitclr_exec_tb_top.sv
// self-checking bench for the add-carry, and, branch-on-carry and bit-clear slice
// assumes the rtl/ package, interface and modules are compiled before this file
`timescale 1ns/1ps
`default_nettype none

module logic_branch_bitclr_exec_tb_top;
  // ----------------------------------------------------------------
  // stimulus and observed signals
  // ----------------------------------------------------------------
  logic        core_clk = 1'b0;
  logic        rst;
  logic [15:0] instr;
  logic        instr_valid;
  logic        ext_set_en;
  logic [3:0]  bank_select;
  logic [7:0]  file_rdata;
  logic [20:0] pc;
  logic [11:0] file_addr;
  logic [7:0]  file_wdata;
  logic        file_we;
  logic [7:0]  w_reg;
  logic [4:0]  status_flags;
  logic        indexed_sel;
  logic [1:0]  phase;
  int          num_errors = 0;
  int          n_checks = 0;
  int          cycles = 0;

  logic_branch_bitclr_exec logic_branch_bitclr_exec_i (
    .CORE_CLK     (core_clk),
    .RST          (rst),
    .INSTR        (instr),
    .INSTR_VALID  (instr_valid),
    .EXT_SET_EN   (ext_set_en),
    .BANK_SELECT  (bank_select),
    .FILE_RDATA   (file_rdata),
    .PC           (pc),
    .FILE_ADDR    (file_addr),
    .FILE_WDATA   (file_wdata),
    .FILE_WE      (file_we),
    .W_REG        (w_reg),
    .STATUS_FLAGS (status_flags),
    .INDEXED_SEL  (indexed_sel),
    .PHASE        (phase)
  );

  // 10 mhz core clock
  always #50 core_clk = ~core_clk;

  // hang guard: the run needs a few hundred clocks at most
  always @(posedge core_clk) begin
    cycles <= cycles + 1;
    if (cycles == 2000) begin
      num_errors = num_errors + 1;
      $display("Error at %0t: run did not finish", $time);
      end_sim();
    end
  end

  // ----------------------------------------------------------------
  // compare and drive helpers
  // ----------------------------------------------------------------
  task automatic chk_val(input logic [20:0] got, input logic [20:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
    end
  endtask : chk_val

  task automatic chk_bit(input logic got, input logic exp, input string what);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: %s got %b expected %b", $time, what, got, exp);
    end
  endtask : chk_bit

  // results of one instruction, sampled mid-cycle after its write edge
  task automatic look(input logic [7:0] w, input logic [4:0] st, input logic [20:0] p,
                      input logic we, input logic [7:0] wd);
    chk_val({13'h0, w_reg}, {13'h0, w}, "work register");
    chk_val({16'h0, status_flags}, {16'h0, st}, "status");
    chk_val(pc, p, "program counter");
    chk_bit(file_we, we, "write strobe");
    if (we)
      chk_val({13'h0, file_wdata}, {13'h0, wd}, "write data");
  endtask : look

  task automatic look_addr(input logic [11:0] a, input logic idx);
    chk_val({9'h0, file_addr}, {9'h0, a}, "file address");
    chk_bit(indexed_sel, idx, "indexed select");
  endtask : look_addr

  // drive on the write edge so the word is settled before the decode edge
  task automatic start(input logic [15:0] ins, input logic [7:0] rd, input logic ext,
                       input logic [3:0] bank_select_register);
    int k;
    k = 0;
    @(negedge core_clk);
    while (phase !== 2'h3 && k < 8) begin
      @(negedge core_clk);
      k++;
    end
    @(posedge core_clk);
    instr       <= ins;
    instr_valid <= 1'b1;
    ext_set_en  <= ext;
    bank_select <= bank_select_register;
    file_rdata  <= rd;
    @(posedge core_clk);
    instr_valid <= 1'b0;
  endtask : start

  // read, process and write edges, then settle
  task automatic finish_op;
    repeat (3) @(posedge core_clk);
    @(negedge core_clk);
  endtask : finish_op

  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task automatic t_reset;
    @(negedge core_clk);
    chk_val({19'h0, phase}, 21'h0, "phase");
    look(8'h00, 5'h00, 21'h0, 1'b0, 8'h00);
    look_addr(12'h000, 1'b0);
    $display("test reset done");
  endtask : t_reset

  task automatic t_add;
    start(16'h2010, 8'h4d, 1'b0, 4'h0);
    finish_op;
    look(8'h4d, 5'h00, 21'h2, 1'b0, 8'h00);
    look_addr(12'h010, 1'b0);
    start(16'h2334, 8'hc0, 1'b0, 4'h5);
    finish_op;
    look(8'h4d, 5'h01, 21'h4, 1'b1, 8'h0d);
    look_addr(12'h534, 1'b0);
    $display("test add done");
  endtask : t_add

  task automatic t_branch_taken;
    start(16'he2fe, 8'h00, 1'b0, 4'h0);
    repeat (2) @(posedge core_clk);
    @(negedge core_clk);
    chk_val(pc, 21'h6, "fetch advance");
    @(posedge core_clk);
    instr       <= 16'h2102;
    instr_valid <= 1'b1;
    @(negedge core_clk);
    look(8'h4d, 5'h01, 21'h2, 1'b0, 8'h00);
    @(posedge core_clk);
    instr_valid <= 1'b0;
    finish_op;
    look(8'h4d, 5'h01, 21'h2, 1'b0, 8'h00);
    $display("test branch_taken done");
  endtask : t_branch_taken

  task automatic t_add_flags;
    start(16'h2102, 8'h02, 1'b1, 4'h2);
    finish_op;
    look(8'h50, 5'h02, 21'h4, 1'b0, 8'h00);
    look_addr(12'h202, 1'b0);
    start(16'h2070, 8'h30, 1'b1, 4'h2);
    finish_op;
    look(8'h80, 5'h18, 21'h6, 1'b0, 8'h00);
    look_addr(12'hf70, 1'b0);
    $display("test add_flags done");
  endtask : t_add_flags

  task automatic t_branch_not;
    start(16'he205, 8'h00, 1'b0, 4'h0);
    finish_op;
    look(8'h80, 5'h18, 21'h8, 1'b0, 8'h00);
    $display("test branch_not done");
  endtask : t_branch_not

  task automatic t_and;
    start(16'h1780, 8'hc2, 1'b0, 4'h3);
    finish_op;
    look(8'h80, 5'h18, 21'ha, 1'b1, 8'h80);
    look_addr(12'h380, 1'b0);
    start(16'h1420, 8'h0f, 1'b1, 4'h3);
    finish_op;
    look(8'h00, 5'h0c, 21'hc, 1'b0, 8'h00);
    look_addr(12'h020, 1'b1);
    $display("test and done");
  endtask : t_and

  task automatic t_bit_clear;
    start(16'h9e5f, 8'hc7, 1'b1, 4'h0);
    finish_op;
    look(8'h00, 5'h0c, 21'he, 1'b1, 8'h47);
    look_addr(12'h05f, 1'b1);
    start(16'h9060, 8'hff, 1'b1, 4'h0);
    finish_op;
    look(8'h00, 5'h0c, 21'h10, 1'b1, 8'hfe);
    look_addr(12'hf60, 1'b0);
    $display("test bit_clear done");
  endtask : t_bit_clear

  // ----------------------------------------------------------------
  // closing report, the single place the run ends
  // ----------------------------------------------------------------
  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : end_sim

  // main sequence: flags carry from one scenario into the next
  initial begin
    rst         = 1'b1;
    instr       = 16'h0000;
    instr_valid = 1'b0;
    ext_set_en  = 1'b0;
    bank_select = 4'h0;
    file_rdata  = 8'h00;
    repeat (12) @(posedge core_clk);
    rst <= 1'b0;
    t_reset;
    t_add;
    t_branch_taken;
    t_add_flags;
    t_branch_not;
    t_and;
    t_bit_clear;
    end_sim();
  end
endmodule : logic_branch_bitclr_exec_tb_top

`default_nettype wire
